/* rtl/hss_pkg.sv */
// Package for the hardwired safety shut-off interlock: registers, fields, timing
`default_nettype none
package hss_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  // Timing figures as printed, in their own units
  localparam int unsigned GLITCH_US = 500;
  localparam int unsigned SHUTOFF_MS = 8;
  localparam int unsigned SKEW_S = 10;
  // Glitch filter: an off pulse of 0.5 ms or less is ignored
  localparam int unsigned GLITCH_CYC = (CLK_HZ / 1_000_000) * GLITCH_US;
  localparam int unsigned SHUTOFF_CYC = (CLK_HZ / 1000) * SHUTOFF_MS;
  localparam longint unsigned SKEW_CYC = longint'(CLK_HZ) * SKEW_S;
  localparam int CNT_W = 32;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  // Control register fields
  localparam int CTRL_SERVO_ON = 0;
  localparam int CTRL_MAINS_OK = 1;
  localparam int CTRL_STOP_MODE = 2;
  localparam int CTRL_UTIL_REQ = 3;
  localparam int CTRL_ALM_CLR = 4;
  localparam int CTRL_FAULT = 5;
  localparam int CTRL_BRK_LO = 8;
  localparam int BRK_W = 16;
  // Status register fields
  localparam int STAT_STATE_LO = 0;
  localparam int STAT_READY = 4;
  localparam int STAT_TALARM = 5;
  localparam int STAT_IN_A = 6;
  localparam int STAT_IN_B = 7;
  localparam int STAT_MON = 8;
  localparam int STAT_UTIL = 9;
  localparam int STAT_DRIVE = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_BRAKE = 4'h4,
    ST_SHUTOFF = 4'h8
  } hss_state_t;
endpackage : hss_pkg
`default_nettype wire

/* rtl/hss_interlock.sv */
// Safety shut-off interlock with AXI4-Lite control and status registers
//
// Overview of operation
// - Either channel alone disables power drive
// - Any input off enters shut-off, no current
// - Both on plus servo off returns idle
// - Servo-on during off keeps shut-off
// - Idle without mains holds until mains on
// - Single channel off over 10 s alarms
// - Power removed within 8 ms of off
// - Off pulses of 0.5 ms ignored by state and monitor, not by drive enables
// - Utility function aborted, needs re-entry
// - Shut-off rejects servo on, ready low
// - Ready only when both on, idle
// - Shut-off drops brake release immediately
// - Stop by configured dynamic brake or coast
// - No fault output during shut-off
// - Monitor on only when both off
// - Monitor on within 8 ms of off
`default_nettype none
module hss_interlock
  import hss_pkg::*;
(
  input wire logic clock, // 200 MHz drive clock
  input wire logic rst_b, // Async reset, active low
  input wire logic safety_input_a, // Channel A, high = on
  input wire logic safety_input_b, // Channel B, high = on
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic drive_en_a, // Power stage enable, channel A
  output logic drive_en_b, // Power stage enable, channel B
  output logic dyn_brake_out, // Dynamic brake engaged
  output logic brake_release_out, // Holding brake released
  output logic fault_out, // Servo alarm output
  output logic external_monitor_out, // High when both channels off
  output logic safety_timing_alarm // Latched channel skew alarm
);

  typedef struct packed {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic filt_a;
    logic filt_b;
    logic [CNT_W-1:0] gl_a;
    logic [CNT_W-1:0] gl_b;
    logic [35:0] skew;
    logic talarm;
    hss_state_t st;
    logic [BRK_W-1:0] brk_cnt;
    logic [31:0] ctrl;
    logic util_run;
    logic util_lock;
    logic drive_a;
    logic drive_b;
    logic dyn;
    logic brk;
    logic fault;
    logic mon;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hss_regs_t;

  hss_regs_t q, d;
  logic servo_on, mains_ok, util_req, alm_clr, fault_req, stop_dyn;
  logic both_on, any_off, both_off;
  logic [31:0] stat;
  logic do_wr;

  // Control fields decoded from the software register
  assign servo_on = q.ctrl[CTRL_SERVO_ON];
  assign mains_ok = q.ctrl[CTRL_MAINS_OK];
  assign stop_dyn = q.ctrl[CTRL_STOP_MODE];
  assign util_req = q.ctrl[CTRL_UTIL_REQ];
  assign alm_clr = q.ctrl[CTRL_ALM_CLR];
  assign fault_req = q.ctrl[CTRL_FAULT];
  assign both_on = q.filt_a & q.filt_b;
  assign both_off = ~q.filt_a & ~q.filt_b;
  assign any_off = ~q.filt_a | ~q.filt_b;

  // Status word assembled from live state
  always_comb
  begin
    stat = '0;
    stat[STAT_STATE_LO +: 4] = q.st;
    stat[STAT_READY] = (q.st == ST_IDLE) & both_on & ~servo_on;
    stat[STAT_TALARM] = q.talarm;
    stat[STAT_IN_A] = q.filt_a;
    stat[STAT_IN_B] = q.filt_b;
    stat[STAT_MON] = q.mon;
    stat[STAT_UTIL] = q.util_run;
    stat[STAT_DRIVE] = q.drive_a;
  end

  // Next-state logic for the whole block
  always_comb
  begin
    d = q;
    d.sync_a = {q.sync_a[0], safety_input_a};
    d.sync_b = {q.sync_b[0], safety_input_b};
    // Off glitch filter
    // On is taken at once; off only once it outlasts the glitch window
    if (q.sync_a[1])
    begin
      d.gl_a = '0;
      d.filt_a = 1'b1;
    end
    else if (q.gl_a > CNT_W'(GLITCH_CYC))
      d.filt_a = 1'b0;
    else
      d.gl_a = q.gl_a + 1'b1;
    if (q.sync_b[1])
    begin
      d.gl_b = '0;
      d.filt_b = 1'b1;
    end
    else if (q.gl_b > CNT_W'(GLITCH_CYC))
      d.filt_b = 1'b0;
    else
      d.gl_b = q.gl_b + 1'b1;

    if (q.filt_a == q.filt_b)
      d.skew = '0;
    else if (q.skew < 36'(SKEW_CYC))
      d.skew = q.skew + 1'b1;
    // Latched alarm, set wins over clear
    if (alm_clr)
      d.talarm = 1'b0;
    if (q.filt_a != q.filt_b && q.skew >= 36'(SKEW_CYC) - 36'h1)
      d.talarm = 1'b1;
    d.ctrl[CTRL_ALM_CLR] = 1'b0;

    // Operating state machine
    unique case (q.st)
      ST_IDLE:
        if (any_off)
          d.st = ST_SHUTOFF;
        else if (servo_on && mains_ok)
          d.st = ST_RUN;
      ST_RUN:
        if (any_off)
          d.st = ST_SHUTOFF;
        else if (!servo_on)
        begin
          d.st = ST_BRAKE;
          d.brk_cnt = q.ctrl[CTRL_BRK_LO +: BRK_W];
        end
      ST_BRAKE:
        if (any_off)
          d.st = ST_SHUTOFF;
        else if (q.brk_cnt == '0)
          d.st = ST_IDLE;
        else
          d.brk_cnt = q.brk_cnt - 1'b1;
      ST_SHUTOFF:
        // Recover only with both on and servo off
        // Main power absence resolves the same way
        if (both_on && !servo_on)
          d.st = ST_IDLE;
      default:
        d.st = ST_SHUTOFF;
    endcase

    // Utility run aborts on shut-off and needs re-entry
    if (!util_req)
      d.util_lock = 1'b0;
    if (d.st == ST_SHUTOFF)
    begin
      d.util_run = 1'b0;
      d.util_lock = 1'b1;
    end
    else if (util_req && !q.util_lock)
      d.util_run = 1'b1;
    else if (!util_req)
      d.util_run = 1'b0;

    // Each channel gates its own drive enable
    // Drive dropped when leaving powered states
    // Removal takes a few cycles, far under 8 ms
    d.drive_a = q.sync_a[1] & q.filt_a & (d.st == ST_RUN || d.st == ST_BRAKE);
    d.drive_b = q.sync_b[1] & q.filt_b & (d.st == ST_RUN || d.st == ST_BRAKE);
    // Stop mode picks dynamic brake or coast
    d.dyn = (d.st == ST_SHUTOFF) & stop_dyn;
    // Brake release cut with no delay in shut-off
    d.brk = (d.st == ST_RUN) | ((d.st == ST_BRAKE) & (q.st != ST_SHUTOFF));
    d.fault = fault_req & (d.st != ST_SHUTOFF);
    // Monitor only on both filtered inputs off
    // Asserted just over 0.5 ms after off, once the glitch filter drops both, well under 8 ms
    d.mon = both_off;

    // AXI4-Lite write: address and data taken in either order
    do_wr = q.aw_got & q.w_got & ~q.bvalid;
    if (s_axi_awvalid && !q.aw_got)
    begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got)
    begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (do_wr)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_SLVERR;
      if (q.awaddr[7:2] == ADDR_CTRL[7:2])
      begin
        d.bresp = RESP_OKAY;
        for (int i = 0; i < 4; i++)
          if (q.wstrb[i])
            d.ctrl[i*8 +: 8] = q.wdata[i*8 +: 8];
      end
      else if (q.awaddr[7:2] == ADDR_STAT[7:2])
        d.bresp = RESP_OKAY;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;

    // AXI4-Lite read: one cycle to answer
    if (s_axi_arvalid && !q.rvalid)
    begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      if (s_axi_araddr[7:2] == ADDR_CTRL[7:2])
        d.rdata = q.ctrl;
      else if (s_axi_araddr[7:2] == ADDR_STAT[7:2])
        d.rdata = stat;
      else
      begin
        d.rdata = '0;
        d.rresp = RESP_SLVERR;
      end
    end
    else if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
  end

  // State register; reset enters shut-off with inputs seen off
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.st <= ST_SHUTOFF;
    end
    else
      q <= d;
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = ~q.aw_got;
  assign s_axi_wready = ~q.w_got;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign drive_en_a = q.drive_a;
  assign drive_en_b = q.drive_b;
  assign dyn_brake_out = q.dyn;
  assign brake_release_out = q.brk;
  assign fault_out = q.fault;
  assign external_monitor_out = q.mon;
  assign safety_timing_alarm = q.talarm;

endmodule : hss_interlock
`default_nettype wire

/* verification/hss_check_sva.sv */
// Checker for the interlock port behaviour
`default_nettype none
module hss_check (
  input wire logic clock, // Drive clock
  input wire logic rst_b, // Reset, active low
  input wire logic safety_input_a, // Channel A
  input wire logic safety_input_b, // Channel B
  input wire logic drive_en_a, // Enable A
  input wire logic drive_en_b, // Enable B
  input wire logic dyn_brake_out, // Dynamic brake
  input wire logic brake_release_out, // Brake release
  input wire logic fault_out, // Alarm out
  input wire logic external_monitor_out, // Monitor
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready // R ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  chan_a_gate_a: assert property (!safety_input_a [*4] |=> !drive_en_a)
    else $error("Drive A on while A off");
  chan_b_gate_a: assert property (!safety_input_b [*4] |=> !drive_en_b)
    else $error("Drive B on while B off");
  mon_no_drive_a: assert property (external_monitor_out |-> !drive_en_a && !drive_en_b)
    else $error("Drive on with monitor on");
  // alarm masked; one cycle slack for the state register
  mon_no_fault_a: assert property (external_monitor_out [*2] |-> !fault_out)
    else $error("Alarm out in shut-off");
  mon_brake_off_a: assert property (external_monitor_out [*2] |-> !brake_release_out)
    else $error("Brake released in shut-off");
  dyn_no_drive_a: assert property (dyn_brake_out |-> !drive_en_a && !drive_en_b)
    else $error("Dynamic brake while driving");
  // Responses are handed over once
  bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response repeated");
  rdata_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read response repeated");
  // The address slot is freed in the cycle the response is raised
  aw_free_a: assert property ($rose(s_axi_bvalid) |-> s_axi_awready)
    else $error("Write address slot held during response");
  // Main scenarios reached
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($fell(drive_en_a));
endmodule : hss_check
bind hss_interlock hss_check hss_check_inst (.clock(clock), .rst_b(rst_b),
  .safety_input_a(safety_input_a), .safety_input_b(safety_input_b),
  .drive_en_a(drive_en_a), .drive_en_b(drive_en_b), .dyn_brake_out(dyn_brake_out),
  .brake_release_out(brake_release_out), .fault_out(fault_out),
  .external_monitor_out(external_monitor_out), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* verification/hss_safety_unit.sv */
// Safety unit model: opens the channels and watches the monitor
`default_nettype none
module hss_safety_unit (
  input wire logic off_a, // Open channel A
  input wire logic off_b, // Open channel B
  input wire logic external_monitor_out, // Feedback
  output logic safety_input_a, // Channel A, high = on
  output logic safety_input_b, // Channel B, high = on
  output logic agree // Feedback matches channels
);
  assign safety_input_a = !off_a;
  assign safety_input_b = !off_b;
  assign agree = external_monitor_out == (off_a && off_b);
endmodule : hss_safety_unit
`default_nettype wire

/* verification/test_hardwired_safety_shutoff.sv */
// Testbench: register sequences against the shut-off interlock
`default_nettype none
module test_hardwired_safety_shutoff
  import hss_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] SON = 32'h1 << CTRL_SERVO_ON;
  localparam logic [31:0] MOK = 32'h1 << CTRL_MAINS_OK;
  localparam logic [31:0] DYN = 32'h1 << CTRL_STOP_MODE;
  localparam logic [31:0] FLT = 32'h1 << CTRL_FAULT;
  localparam logic [31:0] UTL = 32'h1 << CTRL_UTIL_REQ;
  localparam logic [31:0] FAULT_OUT = 32'h1 << CTRL_ALM_CLR;
  // Brake hold of 64 cycles, short enough to watch it expire
  localparam logic [31:0] BDL = 32'h40 << CTRL_BRK_LO;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic off_a = 1'b1;
  logic off_b = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata, rd;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic awr, wr, bv, arr, rv, en_a, en_b, dyn, brk, flt, mon, tal, agree;
  logic [1:0] bresp, rresp, rs;
  wire logic in_a, in_b;
  int fails = 0;
  int comparisons = 0;
  // Clock
  always #2.5 clock = ~clock;
  hss_safety_unit hss_safety_unit_inst (.off_a(off_a), .off_b(off_b),
    .external_monitor_out(mon), .safety_input_a(in_a), .safety_input_b(in_b), .agree(agree));
  hss_interlock hss_interlock_inst (.clock(clock), .rst_b(rst_b),
    .safety_input_a(in_a), .safety_input_b(in_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd), .drive_en_a(en_a),
    .drive_en_b(en_b), .dyn_brake_out(dyn), .brake_release_out(brk), .fault_out(flt),
    .external_monitor_out(mon), .safety_timing_alarm(tal));
  // Verdict and end of run
  task summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One bus transfer; handshakes judged at the falling edge, released after the rising
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, done;
    @(posedge clock);
    if (w)
    begin
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
    end
    else
    begin
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
    end
    done = 1'b0;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(negedge clock);
      ta = awv && awr;
      tw = wv && wr;
      tr = arv && arr;
      done = w ? bv : rv;
      rd = rdata;
      rs = w ? bresp : rresp;
      @(posedge clock);
      if (ta)
        awv <= 1'b0;
      if (tw)
        wv <= 1'b0;
      if (tr)
        arv <= 1'b0;
    end
    brd <= 1'b0;
    rrd <= 1'b0;
    if (!done)
    begin
      fails++;
      summarize();
    end
  endtask : xfer
  task idle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : idle
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    xfer(1'b0, ADDR_STAT, 32'h0);
    check(32'(rd[3:0]), 32'(ST_SHUTOFF));
    check(32'(rd[STAT_MON]), 32'h1);
    idle(1);
    check(32'(mon), 32'h1);
    check(32'(agree), 32'h1);
    check(32'({en_a, en_b}), 32'h0);
    check(32'(dyn), 32'h0);
    check(32'(tal), 32'h0);
    // outputs in shut-off; utility asked while off
    xfer(1'b1, ADDR_CTRL, SON | MOK | DYN | FLT | UTL);
    idle(3);
    check(32'(dyn), 32'h1);
    check(32'(brk), 32'h0);
    check(32'(flt), 32'h0);
    @(posedge clock);
    off_a <= 1'b0;
    off_b <= 1'b0;
    idle(10);
    check(32'(mon), 32'h0);
    xfer(1'b0, ADDR_STAT, 32'h0);
    check(32'(rd[3:0]), 32'(ST_SHUTOFF));
    check(32'(rd[STAT_READY]), 32'h0);
    xfer(1'b1, ADDR_CTRL, MOK | DYN | UTL);
    xfer(1'b0, ADDR_STAT, 32'h0);
    check(32'(rd[3:0]), 32'(ST_IDLE));
    check(32'(rd[STAT_READY]), 32'h1);
    check(32'(rd[STAT_UTIL]), 32'h0);
    xfer(1'b1, ADDR_CTRL, SON | DYN);
    xfer(1'b0, ADDR_STAT, 32'h0);
    check(32'(rd[3:0]), 32'(ST_IDLE));
    xfer(1'b1, ADDR_CTRL, SON | MOK | DYN | FLT | UTL);
    xfer(1'b0, ADDR_STAT, 32'h0);
    check(32'(rd[3:0]), 32'(ST_RUN));
    check(32'(rd[STAT_UTIL]), 32'h1);
    idle(3);
    check(32'({en_a, en_b, dyn, flt}), 32'hD);
    check(32'(brk), 32'h1);
    @(posedge clock);
    off_a <= 1'b1;
    idle(20);
    check(32'({en_a, en_b}), 32'h1);
    @(posedge clock);
    off_b <= 1'b1;
    idle(20);
    check(32'({en_a, en_b, mon}), 32'h0);
    @(posedge clock);
    off_a <= 1'b0;
    off_b <= 1'b0;
    idle(10);
    xfer(1'b0, ADDR_STAT, 32'h0);
    check(32'(rd[3:0]), 32'(ST_RUN));
    // Normal servo-off runs the brake delay, then idles
    xfer(1'b1, ADDR_CTRL, MOK | DYN | BDL | FAULT_OUT);
    xfer(1'b0, ADDR_STAT, 32'h0);
    check(32'(rd[3:0]), 32'(ST_BRAKE));
    check(32'(brk), 32'h1);
    xfer(1'b0, ADDR_CTRL, 32'h0);
    check(rd, MOK | DYN | BDL);
    idle(80);
    check(32'({brk, en_a, en_b}), 32'h0);
    xfer(1'b0, ADDR_STAT, 32'h0);
    check(32'(rd[3:0]), 32'(ST_IDLE));
    check(32'(rd[STAT_READY]), 32'h1);
    // Unmapped place and read-only status
    xfer(1'b0, 8'h08, 32'h0);
    check({rd[29:0], rs}, 32'(RESP_SLVERR));
    xfer(1'b1, ADDR_STAT, 32'h0);
    check(32'(rs), 32'(RESP_OKAY));
    summarize();
  end
endmodule : test_hardwired_safety_shutoff
`default_nettype wire
